// File: wdtu_pkg.sv
package wdtu_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

  // Control register fields
  localparam int unsigned CE_BIT = 4;
  localparam int unsigned EN_BIT = 3;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // Reset status and interrupt fields
  localparam int unsigned CAUSE_BIT = 3;
  localparam int unsigned TIMEOUT_IRQ_BIT = 0;

  // Change-enable window, in system clock cycles
  localparam logic [2:0] CE_HOLD = 3'h4;

  // Shortest period in oscillator cycles, and clocks
  localparam int unsigned BASE_PERIOD = 16384;
  localparam int unsigned SYS_HZ = 10_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: wdtu_sync.sv
`timescale 1ns/1ps
module wdtu_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  if (W < 1) begin
    $error("wdtu_sync: width must be at least one");
  end

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule

// File: wdtu_top.sv
`timescale 1ns/1ps
// Function
// [RULE_01] Counter advances on edges of a separate oscillator of about 1 MHz.
// [RULE_02] The kick instruction clears the counter and starts a new period.
// [RULE_03] Counter is cleared while disabled and on every chip reset.
// [RULE_04] Period elapsing without a kick issues a chip reset.
// [RULE_05] Control bits 7 to 5 always read as zero.
// [RULE_06] Change-enable bit 4 clears itself four system cycles after set.
// [RULE_07] Enable bit 3 sets freely; clearing needs change-enable, else ignored.
// [RULE_08] Software disables with one write of both bits, then zero within four.
// [RULE_09] Selector bits 2..0 pick 16,384 cycles doubling up to 2,097,152.
// [RULE_10] Fuse clear: starts disabled, plain write of enable turns it on.
// [RULE_11] Fuse clear: unlock write, then within four cycles enable and selector.
// [RULE_12] Fuse set: watchdog always runs and enable reads back one.
// [RULE_13] Fuse set: unlock, then selector within four cycles; enable ignored.
// [RULE_14] Timeout gives a one-cycle reset pulse for the reset delay counter.
// [RULE_15] Watchdog reset sets cause flag; power-on or writing zero clears it.
// [RULE_16] Oscillator edges are synchronised before touching counter or compare.
module wdtu_top #(
  parameter int unsigned BASE_PERIOD = wdtu_pkg::BASE_PERIOD,
  parameter int unsigned CNT_W = 22
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // Watchdog oscillator and fuse pins
  input wire logic wdt_osc,
  input wire logic always_on_fuse,
  // Core kick strobe
  input wire logic watchdog_kick_instruction,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [wdtu_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [wdtu_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [wdtu_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [wdtu_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Reset unit and interrupt
  output logic wdt_reset_pulse,
  output logic watchdog_cause_flag,
  output logic irq
);

  if (wdtu_pkg::OSC_HZ * 4 > wdtu_pkg::SYS_HZ) begin
    $error("wdtu_top: oscillator too fast to sample");
  end
  if (BASE_PERIOD < 2 || (BASE_PERIOD << 7) >= (1 << CNT_W)) begin
    $error("wdtu_top: counter too narrow for longest period");
  end

  logic osc_s;
  logic fuse_s;
  logic osc_d;
  logic tick;

  wdtu_sync #(.W(1)) u_osc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(wdt_osc),
    .q(osc_s)
  ); // RULE_16
  wdtu_sync #(.W(1)) u_fuse_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(always_on_fuse),
    .q(fuse_s)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
    end
  end
  assign tick = osc_s & ~osc_d; // RULE_01

  // Bus slave state
  logic aw_full, w_full, next_aw_full, next_w_full;
  logic [7:0] waddr, next_waddr;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, rd_fire, wr_ok;

  // Watchdog state
  logic en, next_en;
  logic [2:0] sel, next_sel;
  logic [2:0] ce_cnt, next_ce_cnt;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] period_m1;
  logic next_pulse;
  logic ist, next_ist, imask, next_imask, next_irq;
  logic next_flag;
  logic ce, en_eff, expire;
  logic [7:0] ctl_rd;

  assign ce = (ce_cnt != 3'h0);
  assign en_eff = en | fuse_s; // RULE_12
  assign ctl_rd = {3'h0, ce, en_eff, sel}; // RULE_05
  assign period_m1 = (CNT_W'(BASE_PERIOD) << sel) - CNT_W'(1); // RULE_09
  assign expire = en_eff && tick && (cnt >= period_m1);
  assign wr_fire = aw_full && w_full && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wr_ok = wr_fire && wlane;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_waddr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_wbyte = wdata[7:0];
      next_wlane = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      case (waddr)
        wdtu_pkg::OFS_CONTROL, wdtu_pkg::OFS_RESET_STATUS,
        wdtu_pkg::OFS_IRQ_STATUS, wdtu_pkg::OFS_IRQ_MASK: begin
          next_bresp = wdtu_pkg::RESP_OKAY;
        end
        default: begin
          next_bresp = wdtu_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = wdtu_pkg::RESP_OKAY;
      case (araddr)
        wdtu_pkg::OFS_CONTROL: begin
          next_rdata = {24'h0, ctl_rd};
        end
        wdtu_pkg::OFS_RESET_STATUS: begin
          next_rdata = 32'(watchdog_cause_flag) << wdtu_pkg::CAUSE_BIT;
        end
        wdtu_pkg::OFS_IRQ_STATUS: begin
          next_rdata = 32'(ist) << wdtu_pkg::TIMEOUT_IRQ_BIT;
        end
        wdtu_pkg::OFS_IRQ_MASK: begin
          next_rdata = 32'(imask) << wdtu_pkg::TIMEOUT_IRQ_BIT;
        end
        default: begin
          next_rdata = 32'h0;
          next_rresp = wdtu_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      waddr <= 8'h0;
      wbyte <= 8'h0;
      wlane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Control register with timed unlock
  always_comb begin
    next_en = en;
    next_sel = sel;
    next_ce_cnt = ce ? ce_cnt - 3'h1 : 3'h0; // RULE_06
    if (wr_ok && waddr == wdtu_pkg::OFS_CONTROL) begin
      if (wbyte[wdtu_pkg::CE_BIT] && wbyte[wdtu_pkg::EN_BIT]) begin
        next_ce_cnt = wdtu_pkg::CE_HOLD; // RULE_06
        next_en = 1'b1;
      end else if (ce && !wbyte[wdtu_pkg::CE_BIT]) begin
        next_ce_cnt = 3'h0;
        next_sel = wbyte[wdtu_pkg::SEL_LSB +: wdtu_pkg::SEL_W]; // RULE_13
        if (!fuse_s) begin
          next_en = wbyte[wdtu_pkg::EN_BIT]; // RULE_07 RULE_11
        end
      end else if (wbyte[wdtu_pkg::EN_BIT]) begin
        next_en = 1'b1; // RULE_10
      end
    end
  end

  // Counter, expiry, interrupt
  always_comb begin
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (!en_eff || watchdog_kick_instruction) begin
      next_cnt = '0; // RULE_02 RULE_03
    end else if (expire) begin
      next_cnt = '0;
      next_pulse = 1'b1; // RULE_04 RULE_14
    end else if (tick) begin
      next_cnt = cnt + CNT_W'(1);
    end
    next_imask = imask;
    next_ist = ist;
    if (wr_ok && waddr == wdtu_pkg::OFS_IRQ_MASK) begin
      next_imask = wbyte[wdtu_pkg::TIMEOUT_IRQ_BIT];
    end
    if (wr_ok && waddr == wdtu_pkg::OFS_IRQ_STATUS &&
        wbyte[wdtu_pkg::TIMEOUT_IRQ_BIT]) begin
      next_ist = 1'b0;
    end
    if (expire) begin
      next_ist = 1'b1;
    end
    next_irq = next_ist & next_imask;
    next_flag = watchdog_cause_flag;
    if (wr_ok && waddr == wdtu_pkg::OFS_RESET_STATUS &&
        !wbyte[wdtu_pkg::CAUSE_BIT]) begin
      next_flag = 1'b0;
    end
    if (expire) begin
      next_flag = 1'b1; // RULE_15
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= 1'b0;
      sel <= wdtu_pkg::SEL_RESET;
      ce_cnt <= 3'h0;
      cnt <= '0; // RULE_03
      wdt_reset_pulse <= 1'b0;
      ist <= 1'b0;
      imask <= 1'b0;
      irq <= 1'b0;
    end else begin
      en <= next_en;
      sel <= next_sel;
      ce_cnt <= next_ce_cnt;
      cnt <= next_cnt;
      wdt_reset_pulse <= next_pulse;
      ist <= next_ist;
      imask <= next_imask;
      irq <= next_irq;
    end
  end

  // Survives chip reset; power-on or a write of zero clears it
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      watchdog_cause_flag <= 1'b0;
    end else begin
      watchdog_cause_flag <= next_flag;
    end
  end

  logic ctl_wr, unlock_wr;
  assign ctl_wr = wr_ok && waddr == wdtu_pkg::OFS_CONTROL;
  assign unlock_wr = ctl_wr && wbyte[wdtu_pkg::CE_BIT] &&
                     wbyte[wdtu_pkg::EN_BIT];

  property p_ce_window;
    @(posedge aclk) disable iff (!aresetn)
      unlock_wr |=> ce_cnt == wdtu_pkg::CE_HOLD;
  endproperty
  a_ce_window: assert property (p_ce_window) // RULE_06
    else $error("change enable window is not four cycles");

  // Window shrinks by one each cycle unless a control write uses it
  property p_ce_countdown;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !ctl_wr) |=> ce_cnt == $past(ce_cnt) - 3'h1;
  endproperty
  a_ce_countdown: assert property (p_ce_countdown) // RULE_06
    else $error("change enable window did not count down");

  property p_no_disable_locked;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_wr && !ce && !wbyte[wdtu_pkg::EN_BIT] && en) |=> en;
  endproperty
  a_no_disable_locked: assert property (p_no_disable_locked) // RULE_07
    else $error("enable cleared without change enable");

  property p_plain_enable;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_wr && wbyte[wdtu_pkg::EN_BIT]) |=> en;
  endproperty
  a_plain_enable: assert property (p_plain_enable) // RULE_10
    else $error("write of one to enable did not enable");

  property p_unlock_update;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_wr && ce && !wbyte[wdtu_pkg::CE_BIT]) |=>
        sel == $past(wbyte[2:0]) && !ce &&
        (fuse_s || en == $past(wbyte[wdtu_pkg::EN_BIT]));
  endproperty
  a_unlock_update: assert property (p_unlock_update) // RULE_11
    else $error("unlocked write did not apply");

  property p_fuse_reads_one;
    @(posedge aclk) disable iff (!aresetn)
      (rd_fire && araddr == wdtu_pkg::OFS_CONTROL && fuse_s) |=>
        rdata[wdtu_pkg::EN_BIT] && rdata[7:5] == 3'h0;
  endproperty
  a_fuse_reads_one: assert property (p_fuse_reads_one) // RULE_12
    else $error("enable read back zero with fuse set");

  property p_kick_clears;
    @(posedge aclk) disable iff (!aresetn)
      watchdog_kick_instruction |=> cnt == '0 ##1 cnt <= CNT_W'(1);
  endproperty
  a_kick_clears: assert property (p_kick_clears) // RULE_02
    else $error("kick did not clear the counter");

  property p_disabled_clear;
    @(posedge aclk) disable iff (!aresetn)
      !en_eff |=> cnt == '0 && !wdt_reset_pulse;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) // RULE_03
    else $error("counter not cleared while disabled");

  property p_pulse_cause;
    @(posedge aclk) disable iff (!aresetn)
      wdt_reset_pulse |-> $past(cnt) >= $past(period_m1) && $past(tick)
        ##1 !wdt_reset_pulse;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) // RULE_14
    else $error("reset pulse without expiry or too long");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn || !por_n)
      wdt_reset_pulse |-> watchdog_cause_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE_15
    else $error("cause flag not set on watchdog reset");

  property p_tick_sync;
    @(posedge aclk) disable iff (!aresetn)
      tick |-> $past(osc_s) == 1'b0;
  endproperty
  a_tick_sync: assert property (p_tick_sync) // RULE_16
    else $error("tick not from a synchronised edge");

  c_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
    wdt_reset_pulse);
  c_disable: cover property (@(posedge aclk) disable iff (!aresetn)
    ce && $fell(en));
  c_sel_change: cover property (@(posedge aclk) disable iff (!aresetn)
    ce ##1 $changed(sel));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));

endmodule

// File: watchdog_timer_with_timed_unlock_tb_top.sv
`timescale 1ns/1ps
module watchdog_timer_with_timed_unlock_tb_top;
  logic aclk, aresetn, por_n, wdt_osc, always_on_fuse, kick;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pulse, flag, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb;
  int miscompares = 0;
  int checks_done = 0;
  int pulses = 0;
  int cyc;

  // Short base period keeps every timeout within a few thousand cycles
  wdtu_top #(.BASE_PERIOD(16), .CNT_W(12)) dut (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .wdt_osc(wdt_osc),
    .always_on_fuse(always_on_fuse), .watchdog_kick_instruction(kick),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .wdt_reset_pulse(pulse), .watchdog_cause_flag(flag),
    .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Oscillator at one tenth of the system clock
  initial begin
    wdt_osc = 1'b0;
    forever begin
      repeat (5) @(posedge aclk);
      wdt_osc <= ~wdt_osc;
    end
  end

  always @(posedge aclk) if (pulse === 1'b1) pulses <= pulses + 1;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Handshakes are judged on values as they stood at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task automatic chkr(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    chk(n, e, rd);
  endtask

  // Time from start to the reset pulse, in system cycles
  task automatic tmo(input int s, input bit k);
    int lo, hi;
    lo = (160 << s) - 16;
    hi = (160 << s) + 16;
    kick <= k;
    @(posedge aclk);
    kick <= 1'b0;
    cyc = 0;
    while (pulse !== 1'b1) begin
      @(negedge aclk);
      cyc++;
    end
    chk("timeout cycles", 1, cyc > lo && cyc < hi);
    @(negedge aclk);
    chk("pulse width", 0, pulse);
    @(posedge aclk);
  endtask

  task automatic reset;
    aresetn <= 1'b0;
    step(3);
    aresetn <= 1'b1;
    step(4);
  endtask

  task automatic t_plain;
    chkr("control reset", 8'h00, 0);
    chkr("unmapped data", 8'h10, 0);
    chk("unmapped resp", wdtu_pkg::RESP_SLVERR, rs);
    wr(8'h10, 8'h08);
    chk("unmapped wresp", wdtu_pkg::RESP_SLVERR, rs);
    wstrb <= 4'h0;
    wr(8'h00, 8'h08);
    wstrb <= 4'hf;
    chkr("lane off write", 8'h00, 0);
    wr(8'h00, 8'h08);
    chk("write resp", wdtu_pkg::RESP_OKAY, rs);
    tmo(0, 0);
    chk("cause flag", 1, flag);
    wr(8'h00, 8'h00);
    chkr("clear without ce", 8'h00, 8'h08);
  endtask

  task automatic t_irq;
    chkr("irq status", 8'h08, 1);
    chk("irq masked", 0, irq);
    wr(8'h0c, 1);
    step(2);
    chk("irq unmasked", 1, irq);
    wr(8'h08, 1);
    step(2);
    chk("irq cleared", 0, irq);
    wr(8'h04, 0);
    chkr("cause cleared", 8'h04, 0);
  endtask

  task automatic t_kick;
    int p;
    p = pulses;
    repeat (5) begin
      kick <= 1'b1;
      step(1);
      kick <= 1'b0;
      step(80);
    end
    chk("kicked pulses", p, pulses);
  endtask

  task automatic t_ce;
    int p;
    wr(8'h00, 8'hf8);
    step(6);
    wr(8'h00, 8'h00);
    chkr("window expired", 8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    chkr("disabled", 8'h00, 0);
    p = pulses;
    step(400);
    chk("disabled pulses", p, pulses);
    wr(8'h00, 8'h08);
    tmo(0, 0);
  endtask

  task automatic t_sel;
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h09);
    chkr("selector one", 8'h00, 8'h09);
    tmo(1, 1);
    por_n <= 1'b0;
    step(1);
    por_n <= 1'b1;
    step(1);
    chk("power-on clears cause", 0, flag);
  endtask

  task automatic t_lvl2;
    always_on_fuse <= 1'b1;
    reset();
    chkr("level2 enable", 8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h02);
    chkr("level2 selector", 8'h00, 8'h0a);
    tmo(2, 1);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    chkr("level2 no disable", 8'h00, 8'h08);
  endtask

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    por_n = 1'b0;
    wstrb = 4'hf;
    always_on_fuse = 1'b0;
    kick = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    bready = 1'b1;
    rready = 1'b1;
    reset();
    por_n <= 1'b1;
    t_plain();
    t_irq();
    t_kick();
    t_ce();
    t_sel();
    t_lvl2();
    close_out();
  end

  initial begin
    #1000000;
    miscompares++;
    close_out();
  end
endmodule
